/* File: dscp_pkg.sv */
// Purpose: shared constants for the serial DAC command port
// Assumes: 24-bit frames, MSB first, 4-bit command field
// Notes:   APB offsets are byte addresses of 32-bit words
package dscp_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int           FRAME_BITS = 24;
  localparam int           CNT_W      = 5;
  localparam logic [4:0]   CNT_FRAME  = 5'h18;
  localparam logic [4:0]   CNT_MAX    = 5'h1F;
  localparam int           FIXED_BIT  = 20;
  localparam int           ADDR_MSB   = 19;
  localparam int           ADDR_LSB   = 16;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_WR_IN     = 4'h1;
  localparam logic [3:0] CMD_UPDATE    = 4'h2;
  localparam logic [3:0] CMD_WR_UPD    = 4'h3;
  localparam logic [3:0] CMD_WR_CTRL   = 4'h4;
  localparam logic [3:0] CMD_DATA_RST  = 4'h7;
  localparam logic [3:0] CMD_DAISY_OFF = 4'h9;
  localparam logic [3:0] CMD_RB_IN     = 4'hA;
  localparam logic [3:0] CMD_RB_DAC    = 4'hB;
  localparam logic [3:0] CMD_RB_CTRL   = 4'hC;
  localparam logic [3:0] CMD_FULL_RST  = 4'hF;

  // ----------------------------------------------------------------
  // control register fields and codes
  // ----------------------------------------------------------------
  localparam int          CLR_MSB     = 10;
  localparam int          CLR_LSB     = 9;
  localparam int          TSD_BIT     = 6;
  localparam int          PV_MSB      = 4;
  localparam int          PV_LSB      = 3;
  localparam int          SC_BIT      = 12;
  localparam int          BO_BIT      = 11;
  localparam logic [10:0] CTRL_WMASK  = 11'h7_DF;
  localparam logic [10:0] CTRL_RST    = 11'h0_00;
  localparam logic [15:0] CODE_ZERO   = 16'h0000;
  localparam logic [15:0] CODE_MID    = 16'h8000;
  localparam logic [15:0] CODE_FULL   = 16'hFFFF;
  localparam logic [15:0] MASK_12     = 16'hFFF0;
  localparam logic [15:0] MASK_16     = 16'hFFFF;

  // ----------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int PIN_N    = 6;
  localparam int P_SCLK   = 0;
  localparam int P_SYNC   = 1;
  localparam int P_SDI    = 2;
  localparam int P_LOAD   = 3;
  localparam int P_HWRST  = 4;
  localparam int P_CLEAR  = 5;

  // ----------------------------------------------------------------
  // apb map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FAULT  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DAC    = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam int         FLT_SC     = 0;
  localparam int         FLT_BO     = 1;
  localparam int         FLT_OT     = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LATCH = 2'b11
  } dscp_state_t;

endpackage

/* File: dscp_top.sv */
// Purpose: digital front end of a serial-input voltage DAC
// Assumes: pins arrive asynchronous to clk; sclk far below clk/4
// Notes:   fault conditions are injected through the apb fault word
//
// What this block does
// [R1] while frame select low, sample serial input on each serial clock fall
// [R2] a standalone frame holds exactly 24 falling edges, else it is invalid
// [R3] frame select rise latches, decodes and moves the word to its register
// [R4] frame is msb first: 3 ignored bits, zero bit, 4-bit address, 16 data
// [R5] twelve-bit variant takes data from bits 15..4, ignores bits 3..0
// [R6] decode no-ops, input write, update, write and update, control write
// [R7] 0111 is data reset, 1111 full reset, 1000 reserved
// [R8] 1010/1011/1100 read back input/dac/control; 1001 stops daisy shifting
// [R9] after a readback, the next frame carries the register out on sdo
// [R10] sdo goes high impedance whenever frame select is high
// [R11] sdo enabled from reset and needed for readback
// [R12] beyond 24 clocks older bits leave on sdo, changed on rising edges
// [R13] host gives 24 times n clocks for a chain of n devices
// [R14] host keeps exact clock count in free-running or gated mode
// [R15] load held low while shifting updates dac at frame select rise
// [R16] load high while shifting: later load fall with select high updates dac
// [R17] hardware reset pin restores power-on state like software full reset
// [R18] clear fall forces the clear code from control bits 10:9 until reload
// [R19] host holds clear low for the minimum pulse time
// [R20] alert low in power-up and resets, released after first control write
// [R21] on alert host reads control: bit 12 short, bit 11 brownout
// [R22] overtemperature pulls alert low; powers digital off only if enabled
// [R23] output clamped and buffer off until first control write
// [R24] a wrong-count frame changes nothing and runs no command
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module dscp_top #(
  parameter int RES_BITS = 16
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link pins
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  // hardware control pins
  input  wire logic        load_output_n,
  input  wire logic        hw_reset_n,
  input  wire logic        clear_n,
  output logic             alert_n,
  // converter side
  output logic      [15:0] dac_code,
  output logic             out_clamp,
  output logic             digital_off
);

  generate
    if (RES_BITS != 16 && RES_BITS != 12) begin : g_bad_res
      $error("RES_BITS must be 12 or 16");
    end
  endgenerate

  localparam logic [15:0] DATA_MASK =
    (RES_BITS == 12) ? dscp_pkg::MASK_12 : dscp_pkg::MASK_16;

  function automatic logic [15:0] code_of(input logic [1:0] sel);
    unique case (sel)
      2'b00:   code_of = dscp_pkg::CODE_ZERO;
      2'b01:   code_of = dscp_pkg::CODE_MID;
      default: code_of = dscp_pkg::CODE_FULL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge finders
  // ----------------------------------------------------------------
  logic [dscp_pkg::PIN_N-1:0] pin_meta;
  logic [dscp_pkg::PIN_N-1:0] pin_sync;
  logic [dscp_pkg::PIN_N-1:0] pin_prev;
  wire  [dscp_pkg::PIN_N-1:0] pin_raw =
    {clear_n, hw_reset_n, load_output_n, sdi, sync_n, sclk};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 6'h3F;
      pin_sync <= 6'h3F;
      pin_prev <= 6'h3F;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire fall_w [dscp_pkg::PIN_N];
  wire rise_w [dscp_pkg::PIN_N];
  genvar gi;
  generate
    for (gi = 0; gi < dscp_pkg::PIN_N; gi++) begin : g_edge
      assign fall_w[gi] = pin_prev[gi] & ~pin_sync[gi];
      assign rise_w[gi] = ~pin_prev[gi] & pin_sync[gi];
    end
  endgenerate

  wire sclk_fall  = fall_w[dscp_pkg::P_SCLK];
  wire sclk_rise  = rise_w[dscp_pkg::P_SCLK];
  wire sync_fall  = fall_w[dscp_pkg::P_SYNC];
  wire sync_rise  = rise_w[dscp_pkg::P_SYNC];
  wire load_fall  = fall_w[dscp_pkg::P_LOAD];
  wire clear_fall = fall_w[dscp_pkg::P_CLEAR];
  wire sync_hi    = pin_sync[dscp_pkg::P_SYNC];
  wire load_lvl   = pin_sync[dscp_pkg::P_LOAD];
  wire sdi_lvl    = pin_sync[dscp_pkg::P_SDI];
  wire hw_rst     = ~pin_sync[dscp_pkg::P_HWRST];

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  dscp_pkg::dscp_state_t state;
  dscp_pkg::dscp_state_t next_state;
  logic [23:0]           shreg;
  logic [4:0]            bit_cnt;
  logic [15:0]           input_reg;
  logic [15:0]           dac_reg;
  logic [10:0]           ctrl;
  logic                  sc_flag;
  logic                  bo_flag;
  logic                  configured;
  logic                  daisy_en;
  logic                  rb_active;
  logic [2:0]            fault;

  always_comb begin
    next_state = state;
    unique case (state)
      dscp_pkg::ST_IDLE:  if (sync_fall) next_state = dscp_pkg::ST_SHIFT;
      dscp_pkg::ST_SHIFT: if (sync_rise) next_state = dscp_pkg::ST_LATCH;
      dscp_pkg::ST_LATCH: next_state = dscp_pkg::ST_IDLE;
      default:            next_state = dscp_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [3:0]  cmd      = shreg[dscp_pkg::ADDR_MSB:dscp_pkg::ADDR_LSB];
  wire [15:0] data_in  = shreg[15:0] & DATA_MASK;                  // R5
  // chained frames keep the last 24 bits; standalone needs exactly 24
  wire        cnt_ok   = daisy_en ? (bit_cnt >= dscp_pkg::CNT_FRAME)
                                  : (bit_cnt == dscp_pkg::CNT_FRAME); // R2
  wire        frame_ok = cnt_ok && !shreg[dscp_pkg::FIXED_BIT]
                         && !digital_off;                          // R4 R24
  wire        do_cmd   = ce && state == dscp_pkg::ST_LATCH
                         && frame_ok;                              // R3
  wire        is_rb    = cmd == dscp_pkg::CMD_RB_IN
                         || cmd == dscp_pkg::CMD_RB_DAC
                         || cmd == dscp_pkg::CMD_RB_CTRL;          // R8
  wire        soft_full = do_cmd && cmd == dscp_pkg::CMD_FULL_RST; // R7
  wire        full_rst  = !rst_n || hw_rst || soft_full;           // R17
  wire        wr_ctrl   = do_cmd && cmd == dscp_pkg::CMD_WR_CTRL;
  wire [15:0] ctrl_rb   = {3'b000, sc_flag, bo_flag, ctrl};        // R21
  wire [15:0] rb_val    = (cmd == dscp_pkg::CMD_RB_IN)  ? input_reg :
                          (cmd == dscp_pkg::CMD_RB_DAC) ? dac_reg   :
                          ctrl_rb;
  wire [15:0] pv_code   =
    code_of(ctrl[dscp_pkg::PV_MSB:dscp_pkg::PV_LSB]) & DATA_MASK;
  wire [15:0] clr_code  =
    code_of(ctrl[dscp_pkg::CLR_MSB:dscp_pkg::CLR_LSB]) & DATA_MASK;
  wire        async_ld  = load_fall && sync_hi
                          && state == dscp_pkg::ST_IDLE;           // R16

  // ----------------------------------------------------------------
  // shift register, bit count, serial output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (full_rst) begin
      state    <= dscp_pkg::ST_IDLE;
      shreg    <= 24'h00_0000;
      bit_cnt  <= 5'h00;
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      if (state == dscp_pkg::ST_IDLE && sync_fall) begin
        bit_cnt  <= 5'h00;
        sdo      <= shreg[23];
        sdo_oe_n <= !(daisy_en || rb_active);                      // R11
      end
      if (state == dscp_pkg::ST_SHIFT && sclk_fall) begin
        shreg <= {shreg[22:0], sdi_lvl};                           // R1
        if (bit_cnt != dscp_pkg::CNT_MAX)
          bit_cnt <= bit_cnt + 5'h01;
      end
      if (state == dscp_pkg::ST_SHIFT && sclk_rise)
        sdo <= shreg[23];                                          // R12 R9
      if (sync_rise || state != dscp_pkg::ST_SHIFT
          && next_state != dscp_pkg::ST_SHIFT)
        sdo_oe_n <= 1'b1;                                          // R10
      if (do_cmd && is_rb)
        shreg <= {4'h0, cmd, rb_val};                              // R9
    end
  end

  // ----------------------------------------------------------------
  // data, dac and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (full_rst) begin
      input_reg  <= dscp_pkg::CODE_ZERO;
      dac_reg    <= dscp_pkg::CODE_ZERO;
      ctrl       <= dscp_pkg::CTRL_RST;
      configured <= 1'b0;
      daisy_en   <= 1'b1;
      rb_active  <= 1'b0;
    end else if (ce) begin
      if (state == dscp_pkg::ST_LATCH)
        rb_active <= do_cmd && is_rb;
      if (do_cmd) begin                                            // R6
        unique case (cmd)
          dscp_pkg::CMD_WR_IN: begin
            input_reg <= data_in;
            if (!load_lvl)
              dac_reg <= data_in;                                  // R15
          end
          dscp_pkg::CMD_UPDATE:
            dac_reg <= input_reg;
          dscp_pkg::CMD_WR_UPD: begin
            input_reg <= data_in;
            dac_reg   <= data_in;
          end
          dscp_pkg::CMD_WR_CTRL: begin
            ctrl       <= data_in[10:0] & dscp_pkg::CTRL_WMASK;
            configured <= 1'b1;                                    // R23
          end
          dscp_pkg::CMD_DATA_RST: begin
            input_reg <= pv_code;                                  // R7
            dac_reg   <= pv_code;
          end
          dscp_pkg::CMD_DAISY_OFF:
            daisy_en <= 1'b0;                                      // R8
          default: ;
        endcase
      end else if (async_ld) begin
        dac_reg <= input_reg;                                      // R16
      end
      if (clear_fall)
        dac_reg <= clr_code;                                       // R18
    end
  end

  // ----------------------------------------------------------------
  // fault flags, alert, power state
  // ----------------------------------------------------------------
  // a fault seen in the clearing cycle keeps its flag set
  always_ff @(posedge clk) begin
    if (full_rst) begin
      sc_flag     <= 1'b0;
      bo_flag     <= 1'b0;
      alert_n     <= 1'b0;
      out_clamp   <= 1'b1;
      digital_off <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        sc_flag <= 1'b0;
        bo_flag <= 1'b0;
      end
      if (fault[dscp_pkg::FLT_SC])
        sc_flag <= 1'b1;
      if (fault[dscp_pkg::FLT_BO])
        bo_flag <= 1'b1;
      alert_n <= configured && !fault[dscp_pkg::FLT_OT]
                 && !sc_flag && !bo_flag;                          // R20 R22
      out_clamp <= !configured;                                    // R23
      digital_off <= fault[dscp_pkg::FLT_OT]
                     && ctrl[dscp_pkg::TSD_BIT];                   // R22
    end
  end

  assign dac_code = dac_reg;

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  wire hit_fault  = paddr == dscp_pkg::OFS_FAULT;
  wire hit_status = paddr == dscp_pkg::OFS_STATUS;
  wire hit_dac    = paddr == dscp_pkg::OFS_DAC;
  wire hit_ctrl   = paddr == dscp_pkg::OFS_CTRL;
  wire hit_any    = hit_fault || hit_status || hit_dac || hit_ctrl;
  wire apb_setup  = psel && !penable;
  wire apb_wr     = psel && penable && pready && pwrite && hit_fault;
  wire [31:0] rd_mux =
    hit_fault  ? {29'h0000_0000, fault} :
    hit_status ? {24'h00_0000, digital_off, daisy_en, rb_active,
                  out_clamp, alert_n, configured, state} :
    hit_dac    ? {input_reg, dac_reg} :
    hit_ctrl   ? {16'h0000, ctrl_rb} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      fault   <= 3'h0;
    end else if (ce) begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !hit_any;
      prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
      if (apb_wr)
        fault <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || hw_rst);

  chk_sdo_idle_hiz: assert property (                              // R10
    state == dscp_pkg::ST_IDLE |-> sdo_oe_n)
    else $error("sdo driven outside a frame");

  chk_short_frame_drop: assert property (                          // R24
    (ce && state == dscp_pkg::ST_LATCH && bit_cnt < dscp_pkg::CNT_FRAME)
    |=> $stable(input_reg) && $stable(ctrl) && !rb_active)
    else $error("short frame changed state");

  chk_input_write: assert property (                               // R3
    (do_cmd && cmd == dscp_pkg::CMD_WR_IN)
    |=> input_reg == $past(data_in))
    else $error("input write lost");

  chk_sync_load: assert property (                                 // R15
    (do_cmd && cmd == dscp_pkg::CMD_WR_IN && !load_lvl && !clear_fall)
    |=> dac_reg == $past(data_in))
    else $error("synchronous load missed");

  chk_async_load: assert property (                                // R16
    (ce && async_ld && !do_cmd && !clear_fall)
    |=> dac_reg == $past(input_reg))
    else $error("asynchronous load missed");

  chk_clear_code: assert property (                                // R18
    (ce && clear_fall) |=> dac_reg == $past(clr_code))
    else $error("clear code not applied");

  chk_alert_reset: assert property (                               // R20
    !configured |-> !alert_n && out_clamp)
    else $error("alert or clamp released early");

  chk_shift_in: assert property (                                  // R1
    (ce && state == dscp_pkg::ST_SHIFT && sclk_fall)
    |=> shreg[0] == $past(sdi_lvl))
    else $error("serial input not sampled");

  chk_sdo_order: assert property (                                 // R12
    (ce && state == dscp_pkg::ST_SHIFT && sclk_rise)
    |=> sdo == $past(shreg[23]))
    else $error("sdo bit out of order");

  chk_low_bits: assert property (                                  // R5
    RES_BITS == 12 |-> data_in[3:0] == 4'h0)
    else $error("low bits not ignored");

  chk_overtemp: assert property (                                  // R22
    (ce && fault[dscp_pkg::FLT_OT]) ##1 ce
    |-> !alert_n && digital_off == $past(ctrl[dscp_pkg::TSD_BIT]))
    else $error("overtemperature response wrong");

  chk_full_reset: assert property (                                // R7
    soft_full |=> ctrl == dscp_pkg::CTRL_RST && !configured
                  && dac_reg == dscp_pkg::CODE_ZERO)
    else $error("full reset incomplete");

endmodule

/* File: dscp_host.sv */
// Purpose: host serial master model for the dac command port
// Assumes: sclk idles high; one bit every 16 clk
// Notes:   sdi shows the inverted last bit outside frames
`timescale 1ns/1ns
module dscp_host (
  // clock
  input  wire logic clk,
  // serial link
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    sclk   = 1'b1;
    sync_n = 1'b1;
    sdi    = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // caller picks the exact edge count; bits leave msb first
  task automatic frame(input logic [47:0] w, input int n,
                       output logic [47:0] rx);
    rx = '0;
    @(posedge clk);
    sync_n <= 1'b0;
    sdi    <= w[n-1];
    hold(8);
    for (int i = n - 1; i >= 0; i--) begin
      // sdo settles after the rise, read just before the fall
      rx   = {rx[46:0], (sdo_oe_n === 1'b0) ? sdo : 1'bx};
      sclk <= 1'b0;
      hold(8);
      sclk <= 1'b1;
      if (i > 0) sdi <= w[i-1];
      hold(8);
    end
    sync_n <= 1'b1;
    sdi    <= ~w[0];
    hold(8);
  endtask
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the dac command port
// Assumes: zero-wait apb slave, 16-bit build
// Notes:   faults are injected through the apb fault word
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        sclk, sync_n, sdi, sdo, sdo_oe_n, alert_n, ce;
  logic        load_output_n, hw_reset_n, clear_n, out_clamp, digital_off;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dac_code;
  logic [47:0] rx;
  logic        er;
  int          err_total, checks;

  dscp_top i_dscp_top (.clk, .rst_n, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclk, .sync_n, .sdi,
    .sdo, .sdo_oe_n, .load_output_n, .hw_reset_n, .clear_n, .alert_n,
    .dac_code, .out_clamp, .digital_off);
  dscp_host i_dscp_host (.clk, .sclk, .sync_n, .sdi, .sdo, .sdo_oe_n);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("ERROR at %0t: no pready", $time);
      report_and_stop;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one standalone 24-bit command frame
  task automatic fr(input logic [3:0] c, input logic [15:0] d);
    i_dscp_host.frame({24'h00_0000, 4'h0, c, d}, 24, rx);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total     = 0;
    checks        = 0;
    rst_n         = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = '0;
    pwdata        = '0;
    load_output_n = 1'b1;
    hw_reset_n    = 1'b1;
    clear_n       = 1'b1;
    ce            = 1'b1;
    cyc(20);
    rst_n <= 1'b1;
    cyc(4);
    chk(alert_n, 1'h0);
    chk(out_clamp, 1'h1);
    chk(sdo_oe_n, 1'h1);
    fr(dscp_pkg::CMD_WR_CTRL, 16'h0240);
    chk(alert_n, 1'h1);
    chk(out_clamp, 1'h0);
    done("config");
    // daisy on by default: last word latches, first ripples out
    i_dscp_host.frame({24'h03_0F0F, 24'h03_3C3C}, 48, rx);
    chk(rx[23:0], 24'h03_0F0F);
    chk(dac_code, 16'h3C3C);
    i_dscp_host.frame(48'h03_0F0F, 23, rx);
    i_dscp_host.frame(48'h13_0F0F, 24, rx);
    chk(dac_code, 16'h3C3C);
    done("framing");
    fr(4'h1, 16'hABCD);
    chk(dac_code, 16'h3C3C);
    load_output_n <= 1'b0;
    cyc(6);
    chk(dac_code, 16'hABCD);
    load_output_n <= 1'b1;
    fr(4'h1, 16'h1234);
    chk(dac_code, 16'hABCD);
    fr(4'h2, 16'h0000);
    chk(dac_code, 16'h1234);
    load_output_n <= 1'b0;
    fr(4'h1, 16'h5555);
    chk(dac_code, 16'h5555);
    load_output_n <= 1'b1;
    apb(8'h08, 1'b0, 32'h0000_0000);
    chk(rd, 32'h5555_5555);
    apb(8'h10, 1'b0, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    done("load");
    fr(4'h9, 16'h0000);
    i_dscp_host.frame({24'h03_7777, 24'h03_7777}, 48, rx);
    chk(dac_code, 16'h5555);
    fr(4'h1, 16'h6666);
    fr(4'hA, 16'h0000);
    fr(4'hB, 16'h0000);
    chk(rx[23:0], 24'h0A_6666);
    fr(4'hC, 16'h0000);
    chk(rx[23:0], 24'h0B_5555);
    fr(4'h0, 16'h0000);
    chk(rx[23:0], 24'h0C_0240);
    chk(sdo_oe_n, 1'h1);
    done("readback");
    fr(4'h7, 16'h0000);
    chk(dac_code, 16'h0000);
    // frozen clock enable: a clear pulse meanwhile must go unseen
    ce      <= 1'b0;
    clear_n <= 1'b0;
    cyc(6);
    clear_n <= 1'b1;
    cyc(2);
    ce <= 1'b1;
    cyc(6);
    chk(dac_code, 16'h0000);
    clear_n <= 1'b0;
    cyc(6);
    clear_n <= 1'b1;
    cyc(4);
    chk(dac_code, dscp_pkg::CODE_MID);
    fr(4'hF, 16'h0000);
    chk({alert_n, out_clamp, dac_code}, 18'h1_0000);
    fr(4'h4, 16'h0240);
    done("resets");
    apb(8'h00, 1'b1, 32'h0000_0001);
    cyc(6);
    chk(alert_n, 1'h0);
    apb(8'h00, 1'b1, 32'h0000_0000);
    fr(4'hC, 16'h0000);
    fr(4'h0, 16'h0000);
    chk(rx[23:0], 24'h0C_1240);
    apb(8'h0C, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_1240);
    apb(8'h00, 1'b1, 32'h0000_0004);
    cyc(6);
    chk({alert_n, digital_off}, 2'h1);
    apb(8'h00, 1'b1, 32'h0000_0000);
    fr(4'h3, 16'h2222);
    chk(dac_code, 16'h2222);
    hw_reset_n <= 1'b0;
    cyc(6);
    hw_reset_n <= 1'b1;
    cyc(6);
    chk({alert_n, out_clamp, digital_off}, 3'h2);
    chk(dac_code, 16'h0000);
    done("faults");
    report_and_stop;
  end
endmodule
